/* design/plb_defines.vh */
// Purpose: constants for the printer line buffer interface
// Assumes: 40 MHz core clock
// Notes: definitions only
`ifndef PLB_DEFINES_VH
`define PLB_DEFINES_VH

`define PLB_CLK_PERIOD_NS 25
`define PLB_OVERSAMPLE 16
`define PLB_DIV_BASE 260
`define PLB_BAUD_SEL_W 3
`define PLB_BAUD_SEL_MAX 3'h7
`define PLB_DIV_W 16

`define PLB_LINE_WIDTH_FULL 8'h84
`define PLB_LINE_WIDTH_ALT 8'h50
`define PLB_FIFO_DEPTH 256
`define PLB_FIFO_AW 8
`define PLB_FIFO_CW 9

`define PLB_CH_LF 8'h0A
`define PLB_CH_VT 8'h0B
`define PLB_CH_FF 8'h0C
`define PLB_CH_CR 8'h0D
`define PLB_CH_DC3 8'h13
`define PLB_CH_DEL 8'h7F
`define PLB_PRINT_LO 8'h20
`define PLB_PRINT_HI 8'h7E

`define PLB_RX_MID_PHASE 4'h7
`define PLB_RX_END_PHASE 4'hF
`define PLB_RX_LAST_BIT 3'h7

`endif

/* design/plb_line_buffer.v */
// Purpose: line buffer input interface: parallel port, serial receiver, fifo, busy logic
// Assumes: one clock, pins synchronised here, firmware controls on the same clock
// Notes: the fifo is held in flip-flops and read by firmware through a pop strobe
`timescale 1ns/1ps
`include "plb_defines.vh"

// Functional notes
// R1: parallel strobe writes port character into fifo
// R2: receiver ready writes serial character into fifo
// R3: acknowledge pulse after each stored parallel character
// R4: clear receiver ready after serial character stored
// R5: flag CR LF VT FF DC3 DEL
// R6: carry on 132nd printable character
// R7: carry or control character sets busy
// R8: firmware clears busy when fifo empty
// R9: firmware reset zeroes printable counter
// R10: firmware selects 132 character line width
// R11: EIA input overrides TTY input
// R12: firmware selects receiver baud rate
// R13: firmware enables or disables receiver
// R14: receiver deserialises onto shared data bus
// R15: sources drive bus without own register
// R16: fifo keeps count, empty and full
// R17: busy holds until explicitly cleared
// R18: one source served at a time
// R19: acknowledge and clear last one cycle
module plb_line_buffer #(
  parameter [`PLB_DIV_W-1:0] DIV_BASE = `PLB_DIV_BASE
) (
  input wire core_clk_in, // 40 MHz core clock
  input wire arst_n_in, // async reset, active low
  input wire [7:0] par_data_in, // parallel port character pins
  input wire parallel_char_strobe_in, // parallel port strobe pin, active high
  input wire eia_rx_in, // EIA serial line
  input wire tty_rx_in, // TTY serial line
  input wire eia_in_use_in, // EIA interface connected
  input wire [`PLB_BAUD_SEL_W-1:0] fw_baud_sel_in, // baud select, 7 fastest
  input wire fw_rx_enable_in, // receiver enable level
  input wire fw_counter_reset_in, // counter reset pulse
  input wire fw_busy_clear_in, // busy clear pulse
  input wire fw_width_132_in, // 1 selects 132 character lines
  input wire fw_fifo_pop_in, // fifo read pulse
  output reg [7:0] data_bus_out, // shared data bus
  output reg parallel_ack_out, // acknowledge to parallel port
  output reg rx_ready_clear_out, // clear pulse to receiver
  output reg rx_char_ready_out, // receiver has a character
  output reg rx_frame_err_out, // last character had bad stop bit
  output reg busy_out, // busy toward sending device
  output reg ctrl_char_out, // control character stored, pulse
  output reg line_carry_out, // line width reached, pulse
  output reg [7:0] fifo_rd_data_out, // character popped from fifo
  output reg [`PLB_FIFO_CW-1:0] fifo_count_out, // characters held
  output reg fifo_empty_out, // fifo empty
  output reg fifo_full_out // fifo full
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WRITE = 2'h1;
  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;
  localparam [1:0] RX_STOP = 2'h3;

  function is_ctrl;
    input [7:0] ch;
    begin
      is_ctrl = (ch == `PLB_CH_CR) || (ch == `PLB_CH_LF) || (ch == `PLB_CH_VT) ||
        (ch == `PLB_CH_FF) || (ch == `PLB_CH_DC3) || (ch == `PLB_CH_DEL);
    end
  endfunction

  function is_print;
    input [7:0] ch;
    begin
      is_print = (ch >= `PLB_PRINT_LO) && (ch <= `PLB_PRINT_HI);
    end
  endfunction

  // synchronisers: stage 1 read only by stage 2
  reg [7:0] pdata_s1_reg;
  reg [7:0] pdata_s2_reg;
  reg [3:0] pin_s1_reg;
  reg [3:0] pin_s2_reg;
  reg strobe_prev_reg;
  wire strobe_s2 = pin_s2_reg[0];
  wire rx_line = pin_s2_reg[3] ? pin_s2_reg[1] : pin_s2_reg[2]; // R11

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pdata_s1_reg <= 8'h00;
      pdata_s2_reg <= 8'h00;
      pin_s1_reg <= 4'h6;
      pin_s2_reg <= 4'h6;
      strobe_prev_reg <= 1'b0;
    end else begin
      pdata_s1_reg <= par_data_in;
      pdata_s2_reg <= pdata_s1_reg;
      pin_s1_reg <= {eia_in_use_in, tty_rx_in, eia_rx_in, parallel_char_strobe_in};
      pin_s2_reg <= pin_s1_reg;
      strobe_prev_reg <= strobe_s2;
    end
  end

  // baud tick at 16x the bit rate, halving per step down from select 7
  reg [`PLB_DIV_W-1:0] div_cnt_reg;
  wire [`PLB_DIV_W-1:0] div_val = DIV_BASE << (`PLB_BAUD_SEL_MAX - fw_baud_sel_in); // R12
  wire tick = (div_cnt_reg == 16'h0000);

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_reg <= 16'h0000;
    end else if (!fw_rx_enable_in || tick) begin
      div_cnt_reg <= div_val - 16'h0001; // R12
    end else begin
      div_cnt_reg <= div_cnt_reg - 16'h0001;
    end
  end

  // serial receiver, 8 data bits, one stop bit
  reg [1:0] rx_state_reg;
  reg [3:0] rx_phase_reg;
  reg [2:0] rx_bit_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] rx_data_reg;
  reg rx_done_reg;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_state_reg <= RX_IDLE;
      rx_phase_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_frame_err_out <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!fw_rx_enable_in) begin
        rx_state_reg <= RX_IDLE; // R13
        rx_phase_reg <= 4'h0;
      end else if (tick) begin
        rx_phase_reg <= rx_phase_reg + 4'h1;
        case (rx_state_reg)
          RX_IDLE: begin
            rx_phase_reg <= 4'h0;
            if (!rx_line) begin
              rx_state_reg <= RX_START;
            end
          end
          RX_START: begin
            if (rx_phase_reg == `PLB_RX_MID_PHASE) begin
              rx_phase_reg <= 4'h0;
              rx_bit_reg <= 3'h0;
              rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_phase_reg == `PLB_RX_END_PHASE) begin
              rx_shift_reg <= {rx_line, rx_shift_reg[7:1]}; // R14
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == `PLB_RX_LAST_BIT) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_phase_reg == `PLB_RX_END_PHASE) begin
              rx_state_reg <= RX_IDLE;
              rx_data_reg <= rx_shift_reg; // R14
              rx_frame_err_out <= !rx_line;
              rx_done_reg <= rx_line;
            end
          end
          default: begin
            rx_state_reg <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ready flag: a new character wins over a clear in the same cycle
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_char_ready_out <= 1'b0;
    end else if (rx_done_reg) begin
      rx_char_ready_out <= 1'b1;
    end else if (rx_ready_clear_out) begin
      rx_char_ready_out <= 1'b0; // R4
    end
  end

  // fifo storage and pointers
  reg [7:0] fifo_mem [0:`PLB_FIFO_DEPTH-1];
  reg [`PLB_FIFO_AW-1:0] wr_idx_reg;
  reg [`PLB_FIFO_AW-1:0] rd_idx_reg;
  reg [1:0] state_reg;
  reg src_par_reg;
  reg par_pend_reg;
  reg [7:0] char_cnt_reg;
  wire [7:0] line_width = fw_width_132_in ? `PLB_LINE_WIDTH_FULL : `PLB_LINE_WIDTH_ALT; // R10
  wire do_write = (state_reg == ST_WRITE) && !fifo_full_out;
  wire do_pop = fw_fifo_pop_in && !fifo_empty_out;
  wire hit_ctrl = do_write && is_ctrl(data_bus_out); // R5
  wire hit_carry = do_write && is_print(data_bus_out) &&
    (char_cnt_reg + 8'h01 >= line_width); // R6
  wire strobe_rise = strobe_s2 && !strobe_prev_reg;

  always @(posedge core_clk_in) begin
    if (do_write) begin
      fifo_mem[wr_idx_reg] <= data_bus_out; // R1 R2
    end
  end

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_idx_reg <= 8'h00;
      rd_idx_reg <= 8'h00;
      fifo_count_out <= 9'h000;
      fifo_empty_out <= 1'b1;
      fifo_full_out <= 1'b0;
      fifo_rd_data_out <= 8'h00;
    end else begin
      if (do_write) begin
        wr_idx_reg <= wr_idx_reg + 8'h01;
      end
      if (do_pop) begin
        rd_idx_reg <= rd_idx_reg + 8'h01;
        fifo_rd_data_out <= fifo_mem[rd_idx_reg];
      end
      if (do_write && !do_pop) begin
        fifo_count_out <= fifo_count_out + 9'h001; // R16
        fifo_empty_out <= 1'b0;
        fifo_full_out <= (fifo_count_out == `PLB_FIFO_DEPTH - 1);
      end else if (do_pop && !do_write) begin
        fifo_count_out <= fifo_count_out - 9'h001; // R16
        fifo_full_out <= 1'b0;
        fifo_empty_out <= (fifo_count_out == 9'h001);
      end
    end
  end

  // transfer control: parallel first, then serial, one per write cycle
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_IDLE;
      src_par_reg <= 1'b0;
      par_pend_reg <= 1'b0;
      data_bus_out <= 8'h00;
      parallel_ack_out <= 1'b0;
      rx_ready_clear_out <= 1'b0;
    end else begin
      parallel_ack_out <= 1'b0; // R19
      rx_ready_clear_out <= 1'b0; // R19
      if (strobe_rise) begin
        par_pend_reg <= 1'b1; // R1
      end
      case (state_reg)
        ST_IDLE: begin
          if (par_pend_reg) begin
            src_par_reg <= 1'b1; // R18
            data_bus_out <= pdata_s2_reg; // R15
            state_reg <= ST_WRITE;
          end else if (rx_char_ready_out && !rx_ready_clear_out) begin
            src_par_reg <= 1'b0; // R18
            data_bus_out <= rx_data_reg; // R15
            state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (do_write) begin
            state_reg <= ST_IDLE;
            if (src_par_reg) begin
              parallel_ack_out <= 1'b1; // R3
              if (!strobe_rise) begin
                par_pend_reg <= 1'b0;
              end
            end else begin
              rx_ready_clear_out <= 1'b1; // R4
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // printable counter, busy and event pulses
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      char_cnt_reg <= 8'h00;
      busy_out <= 1'b0;
      ctrl_char_out <= 1'b0;
      line_carry_out <= 1'b0;
    end else begin
      ctrl_char_out <= hit_ctrl; // R5
      line_carry_out <= hit_carry; // R6
      if (fw_counter_reset_in || hit_carry) begin
        char_cnt_reg <= 8'h00; // R9
      end else if (do_write && is_print(data_bus_out)) begin
        char_cnt_reg <= char_cnt_reg + 8'h01; // R6
      end
      if (hit_ctrl || hit_carry) begin
        busy_out <= 1'b1; // R7 R17
      end else if (fw_busy_clear_in && fifo_empty_out) begin
        busy_out <= 1'b0; // R8
      end
    end
  end

endmodule

/* dv/plb_host_model.sv */
// Purpose: sending host, parallel port and 8N1 serial line
// Assumes: driven from the core clock edges
// Notes: released parallel pins show the inverse of the last character
`timescale 1ns/1ps
module plb_host_model (
  input wire clk_in, // core clock
  input wire ack_in, // acknowledge from device
  output reg [7:0] data_out, // parallel character
  output reg strobe_out, // parallel strobe
  output reg ser_out // serial line, idle high
);
  initial begin
    data_out = 8'h00;
    strobe_out = 1'b0;
    ser_out = 1'b1;
  end
  task automatic send_par(input [7:0] ch);
    begin
      @(posedge clk_in);
      data_out <= ch;
      strobe_out <= 1'b1;
      @(posedge clk_in iff ack_in === 1'b1);
      strobe_out <= 1'b0;
      data_out <= ~ch;
      @(posedge clk_in);
    end
  endtask
  task automatic send_ser(input [7:0] ch, input integer bit_clks);
    reg [9:0] frame;
    integer i;
    begin
      frame = {1'b1, ch, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge clk_in);
        ser_out <= frame[i];
        repeat (bit_clks - 1) @(posedge clk_in);
      end
    end
  endtask
endmodule

/* dv/plb_line_buffer_sva.sv */
// Purpose: port checks for the printer line buffer
// Assumes: one clock, asynchronous active-low reset
// Notes: bound onto every plb_line_buffer instance
`timescale 1ns/1ps
`include "plb_defines.vh"
module plb_line_buffer_sva (
  input wire core_clk_in, // core clock
  input wire arst_n_in, // reset, active low
  input wire fw_busy_clear_in, // busy clear
  input wire fw_fifo_pop_in, // fifo pop
  input wire [7:0] data_bus_out, // shared bus
  input wire parallel_ack_out, // acknowledge
  input wire rx_ready_clear_out, // receiver clear
  input wire rx_char_ready_out, // receiver ready
  input wire busy_out, // busy
  input wire ctrl_char_out, // control flag
  input wire line_carry_out, // width carry
  input wire [8:0] fifo_count_out, // fill count
  input wire fifo_empty_out // fifo empty
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_rx_rise; $rose(rx_char_ready_out); endsequence
  sequence s_flag; ctrl_char_out || line_carry_out; endsequence
  property p_ack_one; parallel_ack_out |=> !parallel_ack_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_clr_one; rx_ready_clear_out |=> !rx_ready_clear_out; endproperty
  a_clr_one: assert property (p_clr_one) else $error("clear too long");
  property p_rx_served; s_rx_rise |-> ##[1:20] rx_ready_clear_out; endproperty
  a_rx_served: assert property (p_rx_served) else $error("serial char not stored");
  property p_busy_set; s_flag |-> ##[0:1] busy_out; endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");
  property p_busy_hold; busy_out && !(fw_busy_clear_in && fifo_empty_out) |=> busy_out; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  property p_busy_fall; $fell(busy_out) |-> $past(fw_busy_clear_in) && $past(fifo_empty_out);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy cleared wrongly");
  property p_ctrl_code; ctrl_char_out |-> data_bus_out inside {`PLB_CH_CR, `PLB_CH_LF,
    `PLB_CH_VT, `PLB_CH_FF, `PLB_CH_DC3, `PLB_CH_DEL}; endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("bad control flag");
  property p_carry_print; line_carry_out |-> data_bus_out inside {[8'h20:8'h7E]}; endproperty
  a_carry_print: assert property (p_carry_print) else $error("carry on non-printable");
  property p_one_src; !(parallel_ack_out && rx_ready_clear_out); endproperty
  a_one_src: assert property (p_one_src) else $error("two sources at once");
  property p_ack_count; parallel_ack_out && !$past(fw_fifo_pop_in) |->
    fifo_count_out == $past(fifo_count_out) + 9'h001; endproperty
  a_ack_count: assert property (p_ack_count) else $error("ack without store");
endmodule
bind plb_line_buffer plb_line_buffer_sva u_plb_line_buffer_sva (.core_clk_in(core_clk_in),
  .arst_n_in(arst_n_in), .fw_busy_clear_in(fw_busy_clear_in), .fw_fifo_pop_in(fw_fifo_pop_in),
  .data_bus_out(data_bus_out), .parallel_ack_out(parallel_ack_out),
  .rx_ready_clear_out(rx_ready_clear_out), .rx_char_ready_out(rx_char_ready_out),
  .busy_out(busy_out), .ctrl_char_out(ctrl_char_out), .line_carry_out(line_carry_out),
  .fifo_count_out(fifo_count_out), .fifo_empty_out(fifo_empty_out));

/* dv/plb_line_buffer_test.sv */
// Purpose: self-checking bench for plb_line_buffer
// Assumes: DIV_BASE 2, so baud select 7 gives 32 clocks a bit
// Notes: expected characters are queued by the driver and checked on each store
`timescale 1ns/1ps
`include "plb_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module plb_line_buffer_test;
  reg core_clk_in, arst_n_in = 1'b0, eia_in_use_in = 1'b1, fw_rx_enable_in = 1'b1;
  reg fw_counter_reset_in = 1'b0, fw_busy_clear_in = 1'b0, fw_width_132_in = 1'b1;
  reg fw_fifo_pop_in = 1'b0;
  reg [2:0] fw_baud_sel_in = 3'h7;
  wire [7:0] par_data_in, data_bus_out, fifo_rd_data_out;
  wire [8:0] fifo_count_out;
  wire parallel_char_strobe_in, ser, parallel_ack_out, rx_ready_clear_out, rx_char_ready_out;
  wire busy_out, ctrl_char_out, line_carry_out, fifo_empty_out, fifo_full_out, rx_frame_err_out;
  wire eia_rx_in = eia_in_use_in ? ser : 1'b0;
  wire tty_rx_in = eia_in_use_in ? 1'b0 : ser;
  localparam [47:0] CODES = {`PLB_CH_CR, `PLB_CH_LF, `PLB_CH_VT, `PLB_CH_FF, `PLB_CH_DC3,
    `PLB_CH_DEL};
  reg [9:0] expq[$];
  reg [7:0] fifoq[$];
  reg [9:0] nxt;
  integer fails = 0, samples_checked = 0, pc = 0, i;
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  plb_line_buffer #(.DIV_BASE(16'h0002)) u_plb_line_buffer (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .par_data_in(par_data_in),
    .parallel_char_strobe_in(parallel_char_strobe_in), .eia_rx_in(eia_rx_in),
    .tty_rx_in(tty_rx_in), .eia_in_use_in(eia_in_use_in), .fw_baud_sel_in(fw_baud_sel_in),
    .fw_rx_enable_in(fw_rx_enable_in), .fw_counter_reset_in(fw_counter_reset_in),
    .fw_busy_clear_in(fw_busy_clear_in), .fw_width_132_in(fw_width_132_in),
    .fw_fifo_pop_in(fw_fifo_pop_in), .data_bus_out(data_bus_out),
    .parallel_ack_out(parallel_ack_out), .rx_ready_clear_out(rx_ready_clear_out),
    .rx_char_ready_out(rx_char_ready_out), .rx_frame_err_out(rx_frame_err_out),
    .busy_out(busy_out), .ctrl_char_out(ctrl_char_out), .line_carry_out(line_carry_out),
    .fifo_rd_data_out(fifo_rd_data_out),
    .fifo_count_out(fifo_count_out), .fifo_empty_out(fifo_empty_out),
    .fifo_full_out(fifo_full_out));
  plb_host_model u_plb_host_model (.clk_in(core_clk_in), .ack_in(parallel_ack_out),
    .data_out(par_data_in), .strobe_out(parallel_char_strobe_in), .ser_out(ser));
  task automatic expect_char(input [7:0] b);
    reg pr, cy;
    begin
      pr = b >= `PLB_PRINT_LO && b <= `PLB_PRINT_HI;
      pc = pc + pr;
      cy = pr && pc == (fw_width_132_in ? `PLB_LINE_WIDTH_FULL : `PLB_LINE_WIDTH_ALT);
      if (cy) pc = 0;
      expq.push_back({cy, b inside {CODES[47:40], CODES[39:32], CODES[31:24], CODES[23:16],
        CODES[15:8], CODES[7:0]}, b});
      fifoq.push_back(b);
    end
  endtask
  task automatic par(input [7:0] b);
    begin
      expect_char(b);
      u_plb_host_model.send_par(b);
    end
  endtask
  task automatic ser_char(input [7:0] b, input integer clks);
    begin
      if (fw_rx_enable_in) expect_char(b);
      u_plb_host_model.send_ser(b, clks);
      repeat (40) @(posedge core_clk_in);
    end
  endtask
  task automatic drain_and_clear;
    reg [7:0] want;
    begin
      while (fifo_empty_out !== 1'b1) begin
        fw_fifo_pop_in <= 1'b1;
        @(posedge core_clk_in);
        fw_fifo_pop_in <= 1'b0;
        @(posedge core_clk_in);
        want = fifoq.size() ? fifoq.pop_front() : ~fifo_rd_data_out;
        `CHK(fifo_rd_data_out, want)
      end
      fw_busy_clear_in <= 1'b1;
      @(posedge core_clk_in);
      fw_busy_clear_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      `CHK(busy_out, 1'b0)
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // every stored character is compared with the oldest queued expectation
  always @(posedge core_clk_in) begin
    if (parallel_ack_out === 1'b1 || rx_ready_clear_out === 1'b1) begin
      nxt = expq.size() ? expq.pop_front() : 10'h3FF;
      `CHK({line_carry_out, ctrl_char_out, data_bus_out}, nxt)
    end
  end
  initial begin
    #(25 * 20000);
    fails++;
    tally_and_finish;
  end
  initial begin
    i = $urandom(32'h3a07);
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    @(posedge core_clk_in);
    `CHK({busy_out, fifo_full_out, fifo_empty_out, fifo_count_out}, 12'h200)
    par(8'h41);
    fw_counter_reset_in <= 1'b1;
    @(posedge core_clk_in);
    fw_counter_reset_in <= 1'b0;
    pc = 0;
    for (i = 0; i < 6; i++) par(CODES[i*8 +: 8]);
    repeat (4) @(posedge core_clk_in);
    fw_busy_clear_in <= 1'b1;
    @(posedge core_clk_in);
    fw_busy_clear_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    `CHK(busy_out, 1'b1)
    `CHK(fifo_count_out, 9'h007)
    drain_and_clear;
    for (i = 0; i < 132; i++) par(8'h20 + $urandom % 95);
    repeat (4) @(posedge core_clk_in);
    `CHK({busy_out, fifo_count_out}, 10'h284)
    drain_and_clear;
    // short lines and a completely full fifo
    fw_width_132_in <= 1'b0;
    @(posedge core_clk_in);
    for (i = 0; i < 256; i++) par(8'h20 + $urandom % 95);
    repeat (4) @(posedge core_clk_in);
    `CHK({busy_out, fifo_full_out, fifo_count_out}, 11'h700)
    drain_and_clear;
    fw_width_132_in <= 1'b1;
    ser_char($urandom, 32);
    ser_char(`PLB_CH_CR, 32);
    eia_in_use_in <= 1'b0;
    fw_baud_sel_in <= 3'h6;
    repeat (8) @(posedge core_clk_in);
    ser_char($urandom, 64);
    `CHK(rx_frame_err_out, 1'b0)
    fw_rx_enable_in <= 1'b0;
    @(posedge core_clk_in);
    ser_char(8'h55, 64);
    drain_and_clear;
    `CHK(expq.size(), 0)
    `CHK(fifoq.size(), 0)
    tally_and_finish;
  end
endmodule
